// ==== tdm_audio_port_clocking_tb.sv ====
// self-checking bench for both ends of the tdm audio port
`timescale 1ns/10ps
module tdm_audio_port_clocking_tb;
  localparam logic [23:0] SMP = 24'hA5C30F;
  logic       sys_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [1:0] smode   = 2'h0;
  logic       third   = 1'b0;
  logic       xtal    = 1'b0;
  logic       xin     = 1'b0;
  logic       drv     = 1'b0;
  logic [7:0] swid    = 8'h10;
  logic [2:0] addr    = 3'h0;
  logic [7:0] wdata   = 8'h00;
  logic       wr      = 1'b0;
  logic       rd      = 1'b0;
  logic [7:0] rdata;
  logic       rce;
  logic       ssr;
  logic       dsr;
  logic       qsr;
  logic       bq;
  logic       cs;
  logic       cf;
  logic       pf;
  logic       xo;
  int         gap;
  int         fails   = 0;
  int         compares = 0;
  tdp_if link ();
  tdp_device i_tdp_device (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .link(link), .strap_speed_mode(smode), .strap_third_duty(third),
    .strap_use_crystal(xtal), .crystal_input(xin),
    .ext_master_clock(xin), .sample_data(SMP), .sample_channel(),
    .register_control_enable(rce), .single_speed_range(ssr),
    .double_speed_range(dsr), .quad_speed_range(qsr), .crystal_output(xo));
  tdp_host i_tdp_host (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link),
    .drive_clocks(drv), .sync_width(swid), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .bit_out(), .bit_valid());
  tdp_props i_tdp_props (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .bit_clock(link.bit_clock), .frame_sync(link.frame_sync),
    .bit_clock_dev(link.bit_clock_dev),
    .bit_clock_dev_oe(link.bit_clock_dev_oe),
    .bit_clock_host_oe(link.bit_clock_host_oe),
    .frame_sync_dev(link.frame_sync_dev),
    .frame_sync_dev_oe(link.frame_sync_dev_oe),
    .first_serial_audio_out(link.first_serial_audio_out),
    .ctrl_wr(link.ctrl_wr), .ctrl_rd(link.ctrl_rd));
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) bq <= link.bit_clock;
  task tally_and_finish;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task do_rst(input logic [1:0] m, input logic t, x, d);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    smode <= m;
    third <= t;
    xtal <= x;
    drv <= d;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
  endtask : do_rst
  task reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : reg_wr
  task rd_chk(input logic [2:0] a, input logic [7:0] mk, exp);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(rdata & mk, exp);
  endtask : rd_chk
  task nrise;
    pf = cf;
    for (gap = 1; gap < 9; gap++)
    begin
      @(negedge sys_clk);
      if (link.bit_clock && !bq) break;
    end
    if (gap == 9)
    begin
      fails++;
      tally_and_finish;
    end
    cf = link.frame_sync;
    cs = link.first_serial_audio_out;
  endtask : nrise
  task frame_check(input int w);
    int         i;
    logic [31:0] v;
    repeat (300) nrise;
    cf = 1'b1;
    for (i = 0; i < 600 && !(cf && !pf); i++) nrise;
    v[31] = cs;
    for (i = 1; i < 32; i++)
    begin
      nrise;
      v[31-i] = cs;
    end
    chk(v[31:8], SMP);
    chk(v[7:0], 24'h0);
    for (i = 32; i < 300 && cf; i++) nrise;
    chk(i - 1, w);
  endtask : frame_check
  task s_master;
    do_rst(2'h0, 1'b0, 1'b0, 1'b0);
    rd_chk(tdp_pkg::REG_GLOBAL, 8'hFF, 8'h00);
    chk(ssr, 1'b1);
    frame_check(128);
    nrise;
    chk(gap, 2);
    rd_chk(tdp_pkg::REG_STATUS, 8'h08, 8'h08);
  endtask : s_master
  task s_speed;
    int m;
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    for (m = 0; m < 4; m++)
    begin
      @(posedge sys_clk);
      smode <= m[1:0];
      @(negedge sys_clk);
      chk({qsr, dsr, ssr}, m == 3 ? 0 : 1 << m);
    end
  endtask : s_speed
  task s_third;
    do_rst(2'h0, 1'b1, 1'b0, 1'b0);
    nrise;
    nrise;
    chk(gap, 3);
    @(negedge sys_clk);
    chk(link.bit_clock, 1'b0);
    frame_check(128);
  endtask : s_third
  task s_regs;
    do_rst(2'h0, 1'b0, 1'b0, 1'b0);
    reg_wr(tdp_pkg::REG_GLOBAL, 8'h84);
    rd_chk(tdp_pkg::REG_GLOBAL, 8'hFF, 8'h84);
    chk(rce, 1'b1);
    @(posedge sys_clk);
    smode <= 2'h2;
    @(negedge sys_clk);
    chk({qsr, dsr, ssr}, 3'h1);
    nrise;
    nrise;
    chk(gap, 3);
    reg_wr(3'h7, 8'h55);
    rd_chk(3'h7, 8'hFF, 8'h00);
  endtask : s_regs
  task s_xtal;
    int i;
    do_rst(2'h0, 1'b0, 1'b1, 1'b0);
    chk(link.master_clock_oe, 1'b1);
    for (i = 0; i < 4; i++)
    begin
      @(posedge sys_clk);
      xin <= ~xin;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(link.master_clock_out, xin);
      chk(xo, !xin);
    end
    do_rst(2'h0, 1'b0, 1'b0, 1'b0);
    @(negedge sys_clk);
    chk(link.master_clock_oe, 1'b0);
    @(posedge sys_clk);
    xin <= ~xin;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(link.master_clock_out, xin);
    chk(xo, 1'b0);
    nrise;
    nrise;
    chk(gap, 2);
  endtask : s_xtal
  task s_slave(input logic [7:0] w, input int exp);
    swid <= w;
    do_rst(2'h3, 1'b0, 1'b0, 1'b1);
    @(negedge sys_clk);
    chk(link.bit_clock_dev_oe, 1'b0);
    frame_check(exp);
    rd_chk(tdp_pkg::REG_STATUS, 8'h18, 8'h00);
  endtask : s_slave
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    fails++;
    tally_and_finish;
  end
  initial
  begin
    s_master;
    s_speed;
    s_third;
    s_regs;
    s_xtal;
    s_slave(8'h40, 64);
    s_slave(8'hFF, 244);
    tally_and_finish;
  end
endmodule : tdm_audio_port_clocking_tb

// ==== tdp_device.sv ====
// converter end: tdm port timing, straps, register control, mclk buffer
// Function
// - bit clock, frame sync, serial data out
// - single, double, quad frame-rate ranges
// - bit clock is 256 times frame rate
// - master sync high 128; slave 1..244
// - sync and data referenced to rising edge
// - bit clock duty half, third option
// - slave ratios free, standard recommended
// - without register control, straps configure all
// - straps held stable and valid
// - reset held until supplies, clocks stable
// - control mode reuses four strap pins
// - control enable is global bit 7
// - enabled register control ignores straps
// - master clock from crystal or external
// - crystal mode drives buffered master clock
// - frame starts on frame sync rising
// - six 32-bit slots, left-justified, msb first
// - tdm data on first serial output
`timescale 1ns/10ps
module tdp_device (
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  tdp_if.dev                      link,
  input  wire logic [1:0]         strap_speed_mode,
  input  wire logic               strap_third_duty,
  input  wire logic               strap_use_crystal,
  input  wire logic               crystal_input,
  input  wire logic               ext_master_clock,
  input  wire logic [23:0]        sample_data,
  output logic [2:0]              sample_channel,
  output logic                    register_control_enable,
  output logic                    single_speed_range,
  output logic                    double_speed_range,
  output logic                    quad_speed_range,
  output logic                    crystal_output
);
  logic [7:0]  global_q;
  logic [7:0]  rdata_q;
  logic [1:0]  mode;
  logic        third_duty_clock_option;
  logic        use_xtal;
  logic        master;
  logic [1:0]  div_q;
  logic        bclk_q;
  logic        bclk_prev_q;
  logic        rise;
  logic        fall;
  logic [7:0]  bitcnt_q;
  logic        fsync_q;
  logic        fs_in_prev_q;
  logic        fs_rise;
  logic [7:0]  fs_width_q;
  logic        width_err_q;
  logic        sdo_q;
  logic        sr_bit;
  logic        load;
  logic [2:0]  chan_q;
  logic        mclk_q;
  logic        xout_q;
  logic [1:0]  div_top;
  logic [2:0]  nxt_chan;
  tdp_pkg::tdp_state_e state_q;

  // register control overrides straps
  assign register_control_enable = global_q[tdp_pkg::CTRL_ENABLE_BIT];
  always_comb
  begin
    if (register_control_enable)
    begin
      mode                    = global_q[1:0];
      third_duty_clock_option = global_q[tdp_pkg::THIRD_BIT];
      use_xtal                = global_q[tdp_pkg::XTAL_BIT];
    end
    else
    begin
      mode                    = strap_speed_mode;
      third_duty_clock_option = strap_third_duty;
      use_xtal                = strap_use_crystal;
    end
  end
  assign master = (mode != tdp_pkg::SPEED_SLAVE);
  assign single_speed_range = (mode == tdp_pkg::SPEED_SINGLE);
  assign double_speed_range = (mode == tdp_pkg::SPEED_DOUBLE);
  assign quad_speed_range   = (mode == tdp_pkg::SPEED_QUAD);

  // control port on the reused strap pins
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      global_q <= tdp_pkg::GLOBAL_RESET;
    else if (link.ctrl_wr && link.ctrl_addr == tdp_pkg::REG_GLOBAL)
      global_q <= link.ctrl_wdata;
  end
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      rdata_q <= 8'h00;
    else if (link.ctrl_rd)
    begin
      case (link.ctrl_addr)
        tdp_pkg::REG_GLOBAL: rdata_q <= global_q;
        tdp_pkg::REG_STATUS: rdata_q <= {3'h0, width_err_q, master,
                                         chan_q};
        default:             rdata_q <= 8'h00;
      endcase
    end
  end
  assign link.ctrl_rdata = rdata_q;

  // bit clock divider: half or third high
  assign div_top = third_duty_clock_option ? 2'(tdp_pkg::THIRD_DIV - 1)
                                           : 2'(2 * tdp_pkg::HALF_DIV - 1);
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || !master)
      div_q <= 2'h0;
    else if (div_q == div_top)
      div_q <= 2'h0;
    else
      div_q <= div_q + 2'h1;
  end
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || !master)
      bclk_q <= 1'b0;
    else
      bclk_q <= (div_q == div_top) ? 1'b1 : 1'b0;
  end
  assign link.bit_clock_dev    = bclk_q;
  assign link.bit_clock_dev_oe = master;

  // edge detect on the bit clock at the pin
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      bclk_prev_q <= 1'b0;
    else
      bclk_prev_q <= link.bit_clock;
  end
  // master edges from the divider, slave edges from the pin
  assign rise = master ? (div_q == div_top)
                       : (link.bit_clock && !bclk_prev_q);
  assign fall = master ? bclk_q
                       : (!link.bit_clock && bclk_prev_q);

  // frame sync edge on rising bit clock
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      fs_in_prev_q <= 1'b0;
    else if (rise)
      fs_in_prev_q <= link.frame_sync;
  end
  assign fs_rise = rise && link.frame_sync && !fs_in_prev_q;

  // slave sync width monitor
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || fs_rise)
      fs_width_q <= 8'h01;
    else if (rise && link.frame_sync && fs_width_q != 8'hFF)
      fs_width_q <= fs_width_q + 8'h01;
  end
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      width_err_q <= 1'b0;
    else if (!master && rise && link.frame_sync && !fs_rise &&
             fs_width_q >= 8'(tdp_pkg::SLAVE_SYNC_MAX))
      width_err_q <= 1'b1;
    else if (link.ctrl_rd && link.ctrl_addr == tdp_pkg::REG_STATUS)
      width_err_q <= 1'b0;
  end

  // frame bit counter, 256 bits per frame
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      bitcnt_q <= 8'h00;
    else if (rise)
    begin
      if (!master && fs_rise)
        bitcnt_q <= 8'h01;
      else
        bitcnt_q <= bitcnt_q + 8'h01;
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      state_q <= tdp_pkg::TDP_IDLE;
    else
    begin
      case (state_q)
        tdp_pkg::TDP_IDLE: state_q <= master ? tdp_pkg::TDP_RUN
                                             : tdp_pkg::TDP_WAIT;
        tdp_pkg::TDP_WAIT: if (fs_rise || master)
                             state_q <= tdp_pkg::TDP_RUN;
        tdp_pkg::TDP_RUN:  if (!master && fs_rise == 1'b0 &&
                               bitcnt_q == 8'hFF && rise)
                             state_q <= tdp_pkg::TDP_RUN;
        default:           state_q <= tdp_pkg::TDP_IDLE;
      endcase
    end
  end

  // master frame sync: high for first 128 bits
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || !master)
      fsync_q <= master; // sync idles high so frame 0 is whole
    else if (fall)
      fsync_q <= (bitcnt_q < 8'(tdp_pkg::SYNC_HIGH_BITS));
  end
  assign link.frame_sync_dev    = fsync_q;
  assign link.frame_sync_dev_oe = master;

  // slot sequencing and serial data
  // load on the last bit of the slot before, msb leads the slot
  assign nxt_chan = bitcnt_q[7:5] + 3'h1;
  assign load = fall && bitcnt_q[4:0] == 5'h1F &&
                state_q == tdp_pkg::TDP_RUN;
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      chan_q <= 3'h0;
    else if (fall && bitcnt_q[4:0] == 5'h1F)
      chan_q <= nxt_chan;
  end
  assign sample_channel = chan_q;
  tdp_slot_shift i_tdp_slot_shift (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .load    (load && nxt_chan < 3'(tdp_pkg::NUM_CHANNELS)),
    .shift   (fall),
    .sample  (sample_data),
    .bit_out (sr_bit)
  );
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      sdo_q <= 1'b0;
    else if (fall)
      sdo_q <= (chan_q < 3'(tdp_pkg::NUM_CHANNELS)) ? sr_bit : 1'b0;
  end
  assign link.first_serial_audio_out = sdo_q;

  // master clock source and buffered copy
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      mclk_q <= 1'b0;
    else
      mclk_q <= use_xtal ? crystal_input : ext_master_clock;
  end
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      xout_q <= 1'b0;
    else
      xout_q <= use_xtal ? !crystal_input : 1'b0;
  end
  assign crystal_output         = xout_q;
  assign link.master_clock_out  = mclk_q;
  assign link.master_clock_oe   = use_xtal;
endmodule : tdp_device

// ==== tdp_host.sv ====
// controller end: register access and slave bit clock / frame sync source
`timescale 1ns/10ps
module tdp_host (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  tdp_if.host              link,
  input  wire logic        drive_clocks,
  input  wire logic [7:0]  sync_width,
  input  wire logic [2:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [7:0]       rdata,
  output logic             bit_out,
  output logic             bit_valid
);
  logic [7:0] rdata_q;
  logic       rd_q;
  logic       wr_q;
  logic       rdp_q;
  logic [2:0] addr_q;
  logic [7:0] wdata_q;
  logic       bclk_q;
  logic       fs_q;
  logic [7:0] cnt_q;
  logic       prev_q;
  logic       bit_q;
  logic       val_q;
  logic [7:0] width;

  // control writes and reads to the device
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      wr_q    <= 1'b0;
      rd_q    <= 1'b0;
      addr_q  <= 3'h0;
      wdata_q <= 8'h00;
    end
    else
    begin
      wr_q    <= wr;
      rd_q    <= rd;
      addr_q  <= addr;
      wdata_q <= wdata;
    end
  end
  assign link.ctrl_wr    = wr_q;
  assign link.ctrl_rd    = rd_q;
  assign link.ctrl_addr  = addr_q;
  assign link.ctrl_wdata = wdata_q;
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      rdp_q <= 1'b0;
    else
      rdp_q <= rd_q;
  end
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      rdata_q <= 8'h00;
    else if (rdp_q)
      rdata_q <= link.ctrl_rdata;
  end
  assign rdata = rdata_q;

  // slave clocking: 256 bits per frame, sync width clamped
  assign width = (sync_width == 8'h00) ? 8'(tdp_pkg::SLAVE_SYNC_MIN) :
                 (sync_width > 8'(tdp_pkg::SLAVE_SYNC_MAX)) ?
                 8'(tdp_pkg::SLAVE_SYNC_MAX) : sync_width;
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || !drive_clocks)
      bclk_q <= 1'b0;
    else
      bclk_q <= !bclk_q;
  end
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || !drive_clocks)
      cnt_q <= 8'h00;
    else if (bclk_q)
      cnt_q <= cnt_q + 8'h01;
  end
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || !drive_clocks)
      fs_q <= 1'b0;
    else if (bclk_q)
      fs_q <= (cnt_q + 8'h01) < width || (cnt_q == 8'hFF);
  end
  assign link.bit_clock_host      = bclk_q;
  assign link.bit_clock_host_oe   = drive_clocks;
  assign link.frame_sync_host     = fs_q;
  assign link.frame_sync_host_oe  = drive_clocks;

  // sample serial data on rising bit clock
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      prev_q <= 1'b0;
    else
      prev_q <= link.bit_clock;
  end
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      bit_q <= 1'b0;
      val_q <= 1'b0;
    end
    else
    begin
      val_q <= link.bit_clock && !prev_q;
      if (link.bit_clock && !prev_q)
        bit_q <= link.first_serial_audio_out;
    end
  end
  assign bit_out   = bit_q;
  assign bit_valid = val_q;
endmodule : tdp_host

// ==== tdp_if.sv ====
// link and control carrier between converter and controller
`timescale 1ns/10ps
interface tdp_if;
  logic       bit_clock_dev;
  logic       bit_clock_dev_oe;
  logic       bit_clock_host;
  logic       bit_clock_host_oe;
  logic       frame_sync_dev;
  logic       frame_sync_dev_oe;
  logic       frame_sync_host;
  logic       frame_sync_host_oe;
  logic       first_serial_audio_out;
  logic       master_clock_out;
  logic       master_clock_oe;
  logic       ctrl_wr;
  logic [2:0] ctrl_addr;
  logic [7:0] ctrl_wdata;
  logic       ctrl_rd;
  logic [7:0] ctrl_rdata;
  wire bit_clock  = bit_clock_dev_oe ? bit_clock_dev : bit_clock_host;
  wire frame_sync = frame_sync_dev_oe ? frame_sync_dev : frame_sync_host;
  modport dev (
    output bit_clock_dev, bit_clock_dev_oe, frame_sync_dev,
           frame_sync_dev_oe, first_serial_audio_out,
           master_clock_out, master_clock_oe, ctrl_rdata,
    input  bit_clock, frame_sync, ctrl_wr, ctrl_addr, ctrl_wdata, ctrl_rd
  );
  modport host (
    output bit_clock_host, bit_clock_host_oe, frame_sync_host,
           frame_sync_host_oe, ctrl_wr, ctrl_addr, ctrl_wdata, ctrl_rd,
    input  bit_clock, frame_sync, first_serial_audio_out, ctrl_rdata,
           master_clock_out, master_clock_oe
  );
endinterface : tdp_if

// ==== tdp_pkg.sv ====
// shared constants for the tdm audio port
package tdp_pkg;
  localparam int unsigned SYS_CLK_HZ       = 25000000;
  localparam int unsigned SLOT_BITS        = 32;
  localparam int unsigned SAMPLE_BITS      = 24;
  localparam int unsigned NUM_CHANNELS     = 6;
  localparam int unsigned FRAME_BITS       = 256;
  localparam int unsigned SYNC_HIGH_BITS   = 128;
  localparam int unsigned SLAVE_SYNC_MIN   = 1;
  localparam int unsigned SLAVE_SYNC_MAX   = 244;
  localparam int unsigned HALF_DIV         = 1;
  localparam int unsigned THIRD_DIV        = 3;
  localparam int unsigned CTRL_ENABLE_BIT  = 7;
  localparam logic [1:0]  SPEED_SINGLE     = 2'h0;
  localparam logic [1:0]  SPEED_DOUBLE     = 2'h1;
  localparam logic [1:0]  SPEED_QUAD       = 2'h2;
  localparam logic [1:0]  SPEED_SLAVE      = 2'h3;
  localparam int unsigned SINGLE_MAX_KHZ   = 54;
  localparam int unsigned DOUBLE_MAX_KHZ   = 108;
  localparam int unsigned QUAD_MAX_KHZ     = 216;
  localparam logic [2:0]  REG_GLOBAL       = 3'h0;
  localparam logic [2:0]  REG_STATUS       = 3'h1;
  localparam logic [2:0]  REG_CH_BASE      = 3'h2;
  localparam logic [7:0]  GLOBAL_RESET     = 8'h00;
  localparam int unsigned MODE_LSB         = 0;
  localparam int unsigned THIRD_BIT        = 2;
  localparam int unsigned XTAL_BIT         = 3;
  typedef enum logic [1:0] {
    TDP_IDLE  = 2'b00,
    TDP_RUN   = 2'b01,
    TDP_WAIT  = 2'b10
  } tdp_state_e;
endpackage : tdp_pkg

// ==== tdp_props.sv ====
// checker on the tdm link between both ends
`timescale 1ns/10ps
module tdp_props (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic bit_clock,
  input wire logic frame_sync,
  input wire logic bit_clock_dev,
  input wire logic bit_clock_dev_oe,
  input wire logic bit_clock_host_oe,
  input wire logic frame_sync_dev,
  input wire logic frame_sync_dev_oe,
  input wire logic first_serial_audio_out,
  input wire logic ctrl_wr,
  input wire logic ctrl_rd
);
  logic       bprev_q;
  logic       sprev_q;
  logic [8:0] hi_q;
  logic [8:0] fl_q;
  wire        rise  = bit_clock && !bprev_q && bit_clock_dev_oe;
  wire        start = rise && frame_sync && !sprev_q;
  // bit counts of master frames
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || !bit_clock_dev_oe)
    begin
      bprev_q <= 1'b0;
      sprev_q <= 1'b0;
      hi_q    <= 9'h000;
      fl_q    <= 9'h000;
    end
    else
    begin
      bprev_q <= bit_clock;
      if (rise)
      begin
        sprev_q <= frame_sync;
        hi_q    <= frame_sync ? hi_q + 9'h001 : 9'h000;
        fl_q    <= start ? 9'h001 : (fl_q != 9'h000 ? fl_q + 9'h001 : 9'h000);
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_one_drv;
    !(bit_clock_dev_oe && bit_clock_host_oe);
  endproperty
  a_one_drv: assert property (p_one_drv)
    else $error("two bit clock drivers");
  property p_oe_pair;
    bit_clock_dev_oe == frame_sync_dev_oe;
  endproperty
  a_oe_pair: assert property (p_oe_pair)
    else $error("clock enables disagree");
  property p_hi_one;
    bit_clock_dev_oe && $rose(bit_clock_dev) |=> !bit_clock_dev;
  endproperty
  a_hi_one: assert property (p_hi_one)
    else $error("bit clock high too long");
  property p_lo_max;
    bit_clock_dev_oe && $fell(bit_clock_dev) |=> ##[0:1] bit_clock_dev;
  endproperty
  a_lo_max: assert property (p_lo_max)
    else $error("bit clock low too long");
  property p_dat_fall;
    bit_clock_dev_oe && $changed(first_serial_audio_out)
      |-> $fell(bit_clock_dev);
  endproperty
  a_dat_fall: assert property (p_dat_fall)
    else $error("data moved off falling edge");
  property p_fs_fall;
    frame_sync_dev_oe && $changed(frame_sync_dev) |-> $fell(bit_clock_dev);
  endproperty
  a_fs_fall: assert property (p_fs_fall)
    else $error("sync moved off falling edge");
  property p_fs_width;
    rise && !frame_sync && sprev_q |-> hi_q == 9'h080;
  endproperty
  a_fs_width: assert property (p_fs_width)
    else $error("sync width wrong");
  property p_frame;
    start && fl_q != 9'h000 |-> fl_q == 9'h100;
  endproperty
  a_frame: assert property (p_frame)
    else $error("frame length wrong");
  property p_fill;
    rise && !start && fl_q != 9'h000
      && (fl_q[4:0] >= 5'h18 || fl_q >= 9'h0C0) |-> !first_serial_audio_out;
  endproperty
  a_fill: assert property (p_fill)
    else $error("fill bit not zero");
  property p_strobe;
    !(ctrl_wr && ctrl_rd);
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("both control strobes");
endmodule : tdp_props

// ==== tdp_slot_shift.sv ====
// slot serializer: 24 sample bits msb first, then zero fill
`timescale 1ns/10ps
module tdp_slot_shift (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        load,
  input  wire logic        shift,
  input  wire logic [23:0] sample,
  output logic             bit_out
);
  logic [31:0] sr_q;
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      sr_q <= 32'h0000_0000;
    else if (load)
      sr_q <= {sample, 8'h00};
    else if (shift)
      sr_q <= {sr_q[30:0], 1'b0};
  end
  assign bit_out = sr_q[31];
endmodule : tdp_slot_shift
